// [src/par_pkg.sv]
// constants, carriers and state types of the private address resolver
package par_pkg;
	// register offsets
	localparam logic [11:0] OFS_START = 12'h000;
	localparam logic [11:0] OFS_STOP = 12'h008;
	localparam logic [11:0] OFS_DONE_EV = 12'h100;
	localparam logic [11:0] OFS_MATCH_EV = 12'h104;
	localparam logic [11:0] OFS_NOMATCH_EV = 12'h108;
	localparam logic [11:0] OFS_IRQ_SET = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
	localparam logic [11:0] OFS_STATUS = 12'h400;
	localparam logic [11:0] OFS_ENABLE = 12'h500;
	localparam logic [11:0] OFS_KEY_COUNT = 12'h504;
	localparam logic [11:0] OFS_KEY_PTR = 12'h508;
	localparam logic [11:0] OFS_PKT_PTR = 12'h510;
	localparam logic [11:0] OFS_SCRATCH_PTR = 12'h514;
	// event bit positions in events and irq enable registers
	localparam int EV_DONE = 0;
	localparam int EV_MATCH = 1;
	localparam int EV_NOMATCH = 2;
	// field values and reset values
	localparam logic [1:0] ENABLE_ON = 2'h3;
	localparam logic [1:0] ENABLE_RST = 2'h0;
	localparam logic [4:0] KEY_COUNT_RST = 5'h01;
	localparam logic [4:0] KEY_COUNT_MAX = 5'h10;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;
	localparam logic [2:0] EVENTS_RST = 3'h0;
	localparam logic [31:0] PTR_RST = 32'h00000000;
	// key table layout: one key is 16 bytes, 4 words
	localparam logic [1:0] KEY_LAST_WORD = 2'h3;
	localparam logic [1:0] ADDR_LAST_WORD = 2'h1;

	// memory request carrier
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} par_mem_req_t;

	// hash engine request carrier
	typedef struct packed {
		logic req;
		logic [127:0] key;
		logic [23:0] prand;
	} par_hash_req_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_KEY,
		ST_HASH,
		ST_SCR
	} par_state_t;

	// whole state of the resolver
	typedef struct packed {
		par_state_t state;
		logic stop;
		logic hit;
		logic [1:0] word;
		logic [3:0] kidx;
		logic [47:0] addr;
		logic [127:0] key;
		par_mem_req_t mem;
		par_hash_req_t hash;
		logic [2:0] ev;
		logic [2:0] inten;
		logic [3:0] status;
		logic [1:0] enable;
		logic [4:0] kcount;
		logic [31:0] key_ptr;
		logic [31:0] pkt_ptr;
		logic [31:0] scr_ptr;
		logic [31:0] rdata;
		logic irq;
	} par_core_t;
endpackage : par_pkg

// [src/par_top.sv]
// private address resolver: registers, dma sequencer, events and interrupt
// What this block does
// - start is allowed once the first 6 packet bytes are in ram.
// - keys are fetched from ram starting at the key table pointer.
// - key n starts at byte 16*n of the table; key 15 at 240.
// - writing 1 to start begins resolution; writing 1 to stop halts it.
// - done, matched and not-matched event registers read 1 once generated.
// - irq enable set register enables per event; reads give enable state.
// - irq enable clear register disables per event; reads give enable state.
// - unit enable field value 3 enables the resolver, 0 disables it.
// - matched event when a key resolves the address, else not-matched.
// - stop at first match or after key count keys, then raise done.
`timescale 1ns/1ps
module par_top (
	input wire logic ref_clk, // 200 mhz system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic [11:0] reg_addr, // register byte offset
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [31:0] reg_rdata, // read data, cycle after reg_rd
	output par_pkg::par_mem_req_t mem_o, // ram request
	input wire logic mem_gnt, // ram accepted the request
	input wire logic mem_rvalid, // read data valid
	input wire logic [31:0] mem_rdata, // read data word
	output par_pkg::par_hash_req_t hash_o, // hash engine request
	input wire logic hash_ack, // hash result valid
	input wire logic [23:0] hash_value, // hash of key and prand
	output logic irq // level interrupt
);
	par_pkg::par_core_t s_q;
	par_pkg::par_core_t s_d;
	logic [2:0] ev_set;
	logic [4:0] kc_eff;
	logic [31:0] key_word_addr;
	logic start_cmd;
	logic stop_cmd;

	// trigger decode and effective key count
	assign start_cmd = reg_wr && reg_addr == par_pkg::OFS_START && reg_wdata[0];
	assign stop_cmd = reg_wr && reg_addr == par_pkg::OFS_STOP && reg_wdata[0];
	assign kc_eff = (s_q.kcount > par_pkg::KEY_COUNT_MAX) ? par_pkg::KEY_COUNT_MAX : s_q.kcount;
	assign key_word_addr = s_q.key_ptr + {24'h000000, s_q.kidx, 4'h0};

	// register read mux
	function automatic logic [31:0] read_mux(input par_pkg::par_core_t s, input logic [11:0] a);
		logic [31:0] r;
		r = 32'h00000000;
		case (a)
			par_pkg::OFS_DONE_EV: r = {31'h00000000, s.ev[par_pkg::EV_DONE]};
			par_pkg::OFS_MATCH_EV: r = {31'h00000000, s.ev[par_pkg::EV_MATCH]};
			par_pkg::OFS_NOMATCH_EV: r = {31'h00000000, s.ev[par_pkg::EV_NOMATCH]};
			par_pkg::OFS_IRQ_SET: r = {29'h00000000, s.inten};
			par_pkg::OFS_IRQ_CLR: r = {29'h00000000, s.inten};
			par_pkg::OFS_STATUS: r = {28'h0000000, s.status};
			par_pkg::OFS_ENABLE: r = {30'h00000000, s.enable};
			par_pkg::OFS_KEY_COUNT: r = {27'h0000000, s.kcount};
			par_pkg::OFS_KEY_PTR: r = s.key_ptr;
			par_pkg::OFS_PKT_PTR: r = s.pkt_ptr;
			par_pkg::OFS_SCRATCH_PTR: r = s.scr_ptr;
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction : read_mux

	// next state: registers, sequencer, events
	always_comb
	begin
		s_d = s_q;
		ev_set = 3'h0;
		s_d.rdata = reg_rd ? read_mux(s_q, reg_addr) : 32'h00000000;
		// configuration writes
		if (reg_wr)
		begin
			case (reg_addr)
				par_pkg::OFS_IRQ_SET: s_d.inten = s_q.inten | reg_wdata[2:0];
				par_pkg::OFS_IRQ_CLR: s_d.inten = s_q.inten & ~reg_wdata[2:0];
				par_pkg::OFS_ENABLE: s_d.enable = reg_wdata[1:0];
				par_pkg::OFS_KEY_COUNT: s_d.kcount = reg_wdata[4:0];
				par_pkg::OFS_KEY_PTR: s_d.key_ptr = reg_wdata;
				par_pkg::OFS_PKT_PTR: s_d.pkt_ptr = reg_wdata;
				par_pkg::OFS_SCRATCH_PTR: s_d.scr_ptr = reg_wdata;
				par_pkg::OFS_DONE_EV: if (!reg_wdata[0]) s_d.ev[par_pkg::EV_DONE] = 1'b0;
				par_pkg::OFS_MATCH_EV: if (!reg_wdata[0]) s_d.ev[par_pkg::EV_MATCH] = 1'b0;
				par_pkg::OFS_NOMATCH_EV: if (!reg_wdata[0]) s_d.ev[par_pkg::EV_NOMATCH] = 1'b0;
				default: s_d.ev = s_d.ev;
			endcase
		end
		// a granted request drops; one outstanding access at a time
		if (s_q.mem.req && mem_gnt)
			s_d.mem.req = 1'b0;
		if (stop_cmd && s_q.state != par_pkg::ST_IDLE)
			s_d.stop = 1'b1;
		case (s_q.state)
			par_pkg::ST_IDLE:
			begin
				if (start_cmd && s_q.enable == par_pkg::ENABLE_ON)
				begin
					s_d.state = par_pkg::ST_ADDR;
					s_d.stop = 1'b0;
					s_d.hit = 1'b0;
					s_d.word = 2'h0;
					s_d.kidx = 4'h0;
					s_d.mem = '{req: 1'b1, we: 1'b0, addr: s_q.pkt_ptr, wdata: 32'h00000000};
				end
			end
			par_pkg::ST_ADDR:
			begin
				if (mem_rvalid)
				begin
					if (s_q.word == 2'h0)
						s_d.addr[31:0] = mem_rdata;
					else
						s_d.addr[47:32] = mem_rdata[15:0];
					s_d.word = s_q.word + 2'h1;
					if (s_q.stop || stop_cmd)
					begin
						s_d.state = par_pkg::ST_IDLE;
						ev_set[par_pkg::EV_DONE] = 1'b1;
					end
					else if (s_q.word != par_pkg::ADDR_LAST_WORD)
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: s_q.pkt_ptr + 32'h00000004, wdata: 32'h00000000};
					else if (kc_eff == 5'h00)
					begin
						s_d.state = par_pkg::ST_IDLE;
						ev_set[par_pkg::EV_NOMATCH] = 1'b1;
						ev_set[par_pkg::EV_DONE] = 1'b1;
					end
					else
					begin
						s_d.state = par_pkg::ST_KEY;
						s_d.word = 2'h0;
						s_d.mem = '{req: 1'b1, we: 1'b0, addr: key_word_addr, wdata: 32'h00000000};
					end
				end
			end
			par_pkg::ST_KEY:
			begin
				if (mem_rvalid)
				begin
					s_d.key[s_q.word*32 +: 32] = mem_rdata;
					s_d.word = s_q.word + 2'h1;
					if (s_q.stop || stop_cmd)
					begin
						s_d.state = par_pkg::ST_IDLE;
						ev_set[par_pkg::EV_DONE] = 1'b1;
					end
					else if (s_q.word == par_pkg::KEY_LAST_WORD)
					begin
						s_d.state = par_pkg::ST_HASH;
						s_d.hash.req = 1'b1;
					end
					else
						s_d.mem = '{req: 1'b1, we: 1'b0,
							addr: key_word_addr + {28'h0000000, s_q.word + 2'h1, 2'h0},
							wdata: 32'h00000000};
				end
			end
			par_pkg::ST_HASH:
			begin
				if (hash_ack)
				begin
					s_d.hash.req = 1'b0;
					s_d.hit = hash_value == s_q.addr[23:0];
					s_d.state = par_pkg::ST_SCR;
					s_d.mem = '{req: 1'b1, we: 1'b1, addr: s_q.scr_ptr,
						wdata: {8'h00, hash_value}};
				end
			end
			par_pkg::ST_SCR:
			begin
				if (mem_gnt)
				begin
					s_d.state = par_pkg::ST_IDLE;
					if (s_q.stop || stop_cmd)
						ev_set[par_pkg::EV_DONE] = 1'b1;
					else if (s_q.hit)
					begin
						s_d.status = s_q.kidx;
						ev_set[par_pkg::EV_MATCH] = 1'b1;
						ev_set[par_pkg::EV_DONE] = 1'b1;
					end
					else if (({1'b0, s_q.kidx} + 5'h01) >= kc_eff)
					begin
						ev_set[par_pkg::EV_NOMATCH] = 1'b1;
						ev_set[par_pkg::EV_DONE] = 1'b1;
					end
					else
					begin
						s_d.state = par_pkg::ST_KEY;
						s_d.kidx = s_q.kidx + 4'h1;
						s_d.word = 2'h0;
						s_d.mem = '{req: 1'b1, we: 1'b0,
							addr: key_word_addr + 32'h00000010, wdata: 32'h00000000};
					end
				end
			end
			default: s_d.state = par_pkg::ST_IDLE;
		endcase
		// hardware set wins over a clearing write
		s_d.ev = s_d.ev | ev_set;
		s_d.hash.key = s_d.key;
		s_d.hash.prand = s_d.addr[47:24];
		s_d.irq = |(s_d.ev & s_d.inten);
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '{state: par_pkg::ST_IDLE, stop: 1'b0, hit: 1'b0, word: 2'h0, kidx: 4'h0,
				addr: 48'h000000000000, key: 128'h0, mem: '0, hash: '0,
				ev: par_pkg::EVENTS_RST, inten: par_pkg::IRQ_EN_RST,
				status: par_pkg::STATUS_RST, enable: par_pkg::ENABLE_RST,
				kcount: par_pkg::KEY_COUNT_RST, key_ptr: par_pkg::PTR_RST,
				pkt_ptr: par_pkg::PTR_RST, scr_ptr: par_pkg::PTR_RST,
				rdata: 32'h00000000, irq: 1'b0};
		end
		else
			s_q <= s_d;
	end

	// outputs straight from the state register
	assign reg_rdata = s_q.rdata;
	assign mem_o = s_q.mem;
	assign hash_o = s_q.hash;
	assign irq = s_q.irq;

	// checks on the sequencer and register behaviour
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_start_fetch_addr: assert property (
		s_q.state == par_pkg::ST_IDLE && start_cmd && s_q.enable == par_pkg::ENABLE_ON
		|=> mem_o.req && !mem_o.we && mem_o.addr == $past(s_q.pkt_ptr))
		else $error("start did not fetch the packet address");
	a_key_word_addr: assert property (
		$rose(mem_o.req) && s_q.state == par_pkg::ST_KEY
		|-> mem_o.addr == s_q.key_ptr + {24'h000000, s_q.kidx, 4'h0}
			+ {28'h0000000, s_q.word, 2'h0})
		else $error("key fetch address wrong");
	a_key_table_step: assert property (
		s_q.state == par_pkg::ST_SCR && s_d.state == par_pkg::ST_KEY
		|=> mem_o.addr == $past(s_q.key_ptr) + {24'h000000, s_q.kidx, 4'h0}
			&& s_q.kidx == $past(s_q.kidx) + 4'h1)
		else $error("next key not 16 bytes on");
	a_disabled_no_start: assert property (
		s_q.state == par_pkg::ST_IDLE && s_q.enable != par_pkg::ENABLE_ON
		|=> s_q.state == par_pkg::ST_IDLE)
		else $error("resolver ran while disabled");
	a_match_records_idx: assert property (
		s_q.state == par_pkg::ST_SCR && mem_gnt && s_q.hit && !s_q.stop && !stop_cmd
		|=> s_q.ev[par_pkg::EV_MATCH] && s_q.ev[par_pkg::EV_DONE]
			&& s_q.status == $past(s_q.kidx))
		else $error("match not recorded");
	a_nomatch_limit: assert property (
		$rose(s_q.ev[par_pkg::EV_NOMATCH])
		|-> $past(s_q.state) == par_pkg::ST_ADDR && kc_eff == 5'h00
			|| ({1'b0, $past(s_q.kidx)} + 5'h01) >= kc_eff)
		else $error("not-matched raised before key count reached");
	a_done_after_ram: assert property (
		$rose(s_q.ev[par_pkg::EV_DONE]) |-> !mem_o.req && s_q.state == par_pkg::ST_IDLE)
		else $error("done raised with ram access pending");
	a_stop_no_result: assert property (
		s_q.stop && s_q.state != par_pkg::ST_IDLE ##1 s_q.state == par_pkg::ST_IDLE
		|-> !$rose(s_q.ev[par_pkg::EV_MATCH]) && !$rose(s_q.ev[par_pkg::EV_NOMATCH]))
		else $error("stopped run produced a result");
	a_stop_latched: assert property (
		stop_cmd && s_q.state != par_pkg::ST_IDLE |=> s_q.stop || s_q.state == par_pkg::ST_IDLE)
		else $error("stop trigger lost");
	a_irq_enable_set: assert property (
		reg_wr && reg_addr == par_pkg::OFS_IRQ_SET
		|=> (s_q.inten & $past(reg_wdata[2:0])) == $past(reg_wdata[2:0]))
		else $error("irq enable set failed");
	a_irq_enable_clr: assert property (
		reg_wr && reg_addr == par_pkg::OFS_IRQ_CLR |=> (s_q.inten & $past(reg_wdata[2:0])) == 3'h0)
		else $error("irq enable clear failed");
	a_event_readback: assert property (
		reg_rd && reg_addr == par_pkg::OFS_MATCH_EV
		|=> reg_rdata == {31'h00000000, $past(s_q.ev[par_pkg::EV_MATCH])})
		else $error("event readback wrong");
	a_irq_follows_ev: assert property (
		$rose(s_q.ev[par_pkg::EV_MATCH]) && s_q.inten[par_pkg::EV_MATCH] |-> irq)
		else $error("enabled match event did not raise irq");

	c_match: cover property (s_q.state == par_pkg::ST_SCR ##1 $rose(s_q.ev[par_pkg::EV_MATCH]));
	c_nomatch: cover property ($rose(s_q.ev[par_pkg::EV_NOMATCH]));
	c_stopped: cover property (s_q.stop ##1 s_q.state == par_pkg::ST_IDLE);
	c_second_key: cover property (s_q.state == par_pkg::ST_KEY && s_q.kidx == 4'h1);
endmodule : par_top

// [dv/par_ram_model.sv]
// shared ram and hash engine model behind the resolver's dma and hash ports
`timescale 1ns/1ps
module par_ram_model (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input par_pkg::par_mem_req_t mem_i, // dma request from the resolver
	output logic mem_gnt, // request accepted
	output logic mem_rvalid, // read word valid
	output logic [31:0] mem_rdata, // read word
	input par_pkg::par_hash_req_t hash_i, // hash request
	output logic hash_ack, // hash result valid
	output logic [23:0] hash_value, // hash result
	input wire logic [3:0] slow // wait cycles before each grant
);
	logic [31:0] mem [0:255];
	logic [3:0] wait_q;
	logic [31:0] last_rd;
	int n_hash;
	// grant after the wait, read word one cycle later; idle buses show a moving pattern
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_gnt <= 1'b0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 32'h00000000;
			wait_q <= 4'h0;
			hash_ack <= 1'b0;
			hash_value <= 24'h000000;
			n_hash <= 0;
		end
		else
		begin
			mem_gnt <= mem_i.req && !mem_gnt && wait_q >= slow;
			wait_q <= (mem_i.req && !mem_gnt) ? wait_q + 4'h1 : 4'h0;
			mem_rvalid <= mem_gnt && !mem_i.we;
			mem_rdata <= (mem_gnt && !mem_i.we) ? mem[mem_i.addr[9:2]] : ~mem_rdata;
			if (mem_gnt && mem_i.we)
				mem[mem_i.addr[9:2]] <= mem_i.wdata;
			if (mem_gnt && !mem_i.we)
				last_rd <= mem_i.addr;
			hash_ack <= hash_i.req && !hash_ack;
			hash_value <= (hash_i.req && !hash_ack) ? hash_i.key[23:0] ^ hash_i.prand : ~hash_value;
			if (hash_ack)
				n_hash <= n_hash + 1;
		end
	end
endmodule : par_ram_model

// [dv/test_par_top.sv]
// self-checking bench of the private address resolver
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module test_par_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	par_pkg::par_mem_req_t mem_o;
	par_pkg::par_hash_req_t hash_o;
	logic mem_gnt, mem_rvalid, hash_ack, irq;
	logic [31:0] mem_rdata;
	logic [23:0] hash_value;
	logic [3:0] slow = 4'h0;
	logic [31:0] rd_q;
	int n_fail = 0;
	int checks = 0;
	int base = 0;
	// 200 mhz clock
	always #2.5 ref_clk = ~ref_clk;
	par_top u_par_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_o(mem_o), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.hash_o(hash_o), .hash_ack(hash_ack), .hash_value(hash_value), .irq(irq));
	par_ram_model u_par_ram_model (.ref_clk(ref_clk), .rst_n(rst_n), .mem_i(mem_o),
		.mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .hash_i(hash_o),
		.hash_ack(hash_ack), .hash_value(hash_value), .slow(slow));
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rd_q = reg_rdata;
	endtask : rd
	task automatic chk(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rd_q, e)
	endtask : chk
	task automatic stop_test();
		$display("checks %0d, n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// poll the done event under a bound
	task automatic wait_done();
		int i;
		for (i = 0; i < 400; i++)
		begin
			rd(par_pkg::OFS_DONE_EV);
			if (rd_q === 32'h00000001)
				break;
		end
		if (i == 400)
		begin
			n_fail++;
			stop_test();
		end
	endtask : wait_done
	// load the key table, start a run, optionally stop it at once
	task automatic go(input logic [4:0] kc, input int hit, input logic [3:0] sl, input logic stp);
		for (int k = 0; k < 16; k++)
			u_par_ram_model.mem[16 + 4 * k] = (k == hit) ? 32'h006E0AF3 : 32'h11000000 | 32'(k);
		base = u_par_ram_model.n_hash;
		slow <= sl;
		wr(par_pkg::OFS_KEY_COUNT, {27'h0, kc});
		wr(par_pkg::OFS_START, 32'h00000001);
		if (stp)
			wr(par_pkg::OFS_STOP, 32'h00000001);
		wait_done();
	endtask : go
	task automatic ev_clr();
		wr(par_pkg::OFS_DONE_EV, 32'h00000000);
		wr(par_pkg::OFS_MATCH_EV, 32'h00000000);
		wr(par_pkg::OFS_NOMATCH_EV, 32'h00000000);
		// let the registered irq settle before anyone looks at it
		#1;
	endtask : ev_clr
	task automatic t_reset();
		chk(par_pkg::OFS_KEY_COUNT, 32'h00000001);
		chk(par_pkg::OFS_ENABLE, 32'h00000000);
		chk(par_pkg::OFS_IRQ_SET, 32'h00000000);
		chk(12'h0FC, 32'h00000000);
		wr(par_pkg::OFS_START, 32'h00000001);
		repeat (60) @(posedge ref_clk);
		chk(par_pkg::OFS_DONE_EV, 32'h00000000);
		`CHK(irq, 1'b0)
		$display("reset test done");
	endtask : t_reset
	task automatic t_match();
		wr(par_pkg::OFS_IRQ_SET, 32'h00000002);
		// a key count above sixteen is clamped to sixteen
		go(5'h1F, 15, 4'h2, 1'b0);
		chk(par_pkg::OFS_MATCH_EV, 32'h00000001);
		chk(par_pkg::OFS_NOMATCH_EV, 32'h00000000);
		chk(par_pkg::OFS_STATUS, 32'h0000000F);
		`CHK(u_par_ram_model.last_rd, 32'h0000013C)
		`CHK(u_par_ram_model.n_hash - base, 16)
		`CHK(u_par_ram_model.mem[252], 32'h00123456)
		`CHK(irq, 1'b1)
		chk(par_pkg::OFS_IRQ_CLR, 32'h00000002);
		wr(par_pkg::OFS_IRQ_CLR, 32'h00000002);
		chk(par_pkg::OFS_IRQ_SET, 32'h00000000);
		`CHK(irq, 1'b0)
		ev_clr();
		$display("match test done");
	endtask : t_match
	task automatic t_nomatch();
		wr(par_pkg::OFS_IRQ_SET, 32'h00000004);
		go(5'h03, -1, 4'h0, 1'b0);
		chk(par_pkg::OFS_NOMATCH_EV, 32'h00000001);
		chk(par_pkg::OFS_MATCH_EV, 32'h00000000);
		chk(par_pkg::OFS_STATUS, 32'h0000000F);
		`CHK(u_par_ram_model.last_rd, 32'h0000006C)
		`CHK(u_par_ram_model.n_hash - base, 3)
		`CHK(irq, 1'b1)
		ev_clr();
		`CHK(irq, 1'b0)
		// zero keys: not matched and done straight after the address fetch
		go(5'h00, 0, 4'h0, 1'b0);
		chk(par_pkg::OFS_NOMATCH_EV, 32'h00000001);
		chk(par_pkg::OFS_MATCH_EV, 32'h00000000);
		`CHK(u_par_ram_model.n_hash - base, 0)
		ev_clr();
		$display("no match test done");
	endtask : t_nomatch
	task automatic t_first();
		go(5'h10, 0, 4'h1, 1'b0);
		chk(par_pkg::OFS_MATCH_EV, 32'h00000001);
		chk(par_pkg::OFS_STATUS, 32'h00000000);
		`CHK(u_par_ram_model.n_hash - base, 1)
		`CHK(u_par_ram_model.last_rd, 32'h0000004C)
		ev_clr();
		$display("first key test done");
	endtask : t_first
	task automatic t_stop();
		go(5'h10, -1, 4'hA, 1'b1);
		chk(par_pkg::OFS_MATCH_EV, 32'h00000000);
		chk(par_pkg::OFS_NOMATCH_EV, 32'h00000000);
		`CHK(u_par_ram_model.n_hash - base, 0)
		ev_clr();
		$display("stop test done");
	endtask : t_stop
	// main sequence
	initial
	begin
		for (int i = 0; i < 256; i++)
			u_par_ram_model.mem[i] = 32'h5A000000 | 32'(i);
		u_par_ram_model.mem[0] = 32'hA5123456;
		u_par_ram_model.mem[1] = 32'h00007C3E;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		wr(par_pkg::OFS_KEY_PTR, 32'h00000040);
		wr(par_pkg::OFS_PKT_PTR, 32'h00000000);
		wr(par_pkg::OFS_SCRATCH_PTR, 32'h000003F0);
		wr(par_pkg::OFS_ENABLE, 32'h00000003);
		t_match();
		t_nomatch();
		t_first();
		t_stop();
		stop_test();
	end
endmodule : test_par_top
